/* hdl/mar_pkg.sv */
package mar_pkg;
    localparam int          NUM_AXES           = 4;
    localparam logic [11:0] ADDR_AXIS_MODE_3   = 12'h000;
    localparam logic [11:0] ADDR_GEN_OUT_BANK  = 12'h004;
    localparam logic [11:0] ADDR_INTERP_MODE   = 12'h008;
    localparam logic [11:0] ADDR_CMD_DATA_LOW  = 12'h00c;
    localparam logic [11:0] ADDR_CMD_DATA_HIGH = 12'h010;
    localparam logic [11:0] ADDR_MAIN_STATUS   = 12'h014;
    localparam logic [11:0] ADDR_AXIS_SELECT   = 12'h018;
    localparam logic [15:0] MODE3_WRITE_MASK   = 16'h0f9f;
    localparam logic [15:0] MODE3_RESET        = 16'h0000;
    localparam logic [15:0] GEN_OUT_RESET      = 16'h0000;
    localparam logic [15:0] INTERP_RESET       = 16'h0000;
    localparam int          M3_EXT_LO          = 3;
    localparam int          M3_OUTSEL          = 7;
    localparam int          M3_LEVEL_LO        = 8;
    localparam logic [1:0]  EXT_OFF            = 2'h0;
    localparam logic [1:0]  EXT_CONT           = 2'h1;
    localparam logic [1:0]  EXT_FIXED          = 2'h2;
    localparam logic [1:0]  EXT_MPG            = 2'h3;
    localparam logic [1:0]  VEC_BAD            = 2'h2;

    typedef struct packed {
        logic [1:0] master_axis_select;
        logic [1:0] second_axis_select;
        logic [1:0] third_axis_select;
        logic [1:0] vector_speed_mode;
        logic       external_step_mode;
        logic       command_step_mode;
        logic       interp_irq_enable;
        logic       pattern_irq_enable;
    } mar_interp_cfg_t;

    typedef struct packed {
        logic       cont_plus;
        logic       cont_minus;
        logic       fixed_plus;
        logic       fixed_minus;
    } mar_ext_req_t;
endpackage

/* hdl/mar_regs.sv */
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
// Functional notes
// - external drive field selects input behaviour
// - continuous mode drives while input low
// - fixed mode starts on falling edge
// - mpg mode: edges of plus start drives
// - select zero: upper outputs follow level bits
// - select one: compare results on outputs 4,5
// - select one: accel/decel on outputs 6,7
// - level bit zero low, one high
// - mode three resets zero, reserved written zero
// - output bank drives four outputs per axis
// - axis assignment codes in interpolation register
// - vector speed code ten not permitted
// - bits eleven, twelve select single-step pacing
// - bits fourteen, fifteen enable interpolation interrupts
// - command data split low and high words
// - drive flag covers in-position wait
// - error flag ORs status error bits
// - interpolation drive flag while pulsing
// - next-node ready flag reported
// - circular zone reported in three bits
// - pattern stack count reported
module mar_regs
    import mar_pkg::*;
#(
    parameter int NAXES = NUM_AXES
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [NAXES-1:0]      ext_plus_drive_input_n,
    input  wire logic [NAXES-1:0]      ext_minus_drive_input_n,
    input  wire logic [NAXES-1:0]      pos_ge_plus_cmp,
    input  wire logic [NAXES-1:0]      pos_lt_minus_cmp,
    input  wire logic [NAXES-1:0]      axis_accel,
    input  wire logic [NAXES-1:0]      axis_decel,
    input  wire logic [NAXES-1:0]      axis_pulsing,
    input  wire logic [NAXES-1:0]      home_search_busy,
    input  wire logic [NAXES-1:0]      inpos_check_en,
    input  wire logic [NAXES-1:0]      in_position_input,
    input  wire logic [NAXES*6-1:0]    axis_err_bits,
    input  wire logic [NAXES*4-1:0]    axis_finish_err_bits,
    input  wire logic                  interp_pulsing,
    input  wire logic                  next_node_ready,
    input  wire logic [2:0]            circle_zone,
    input  wire logic [1:0]            pattern_stack_count,
    output mar_ext_req_t [NAXES-1:0]   ext_req,
    output logic [NAXES*4-1:0]         upper_axis_outputs,
    output logic [15:0]                lower_axis_outputs,
    output mar_interp_cfg_t            interp_cfg,
    output logic [31:0]                command_data,
    output logic                       cmd_low_written,
    output logic                       cmd_high_written
);
    logic [15:0]       mode3_q [NAXES];
    logic [15:0]       gen_out_q;
    logic [15:0]       interp_q;
    logic [15:0]       cmd_low_q;
    logic [15:0]       cmd_high_q;
    logic [1:0]        axis_sel_q;
    logic [NAXES-1:0]  plus_prev_q;
    logic [NAXES-1:0]  minus_prev_q;
    logic [NAXES-1:0]  drv_hold_q;
    logic [NAXES-1:0]  axis_driving_flag;
    logic [NAXES-1:0]  axis_err_flag;
    logic [15:0]       main_status;
    logic              wr_en;
    logic              rd_en;
    logic              addr_ok;

    function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] r);
        addr_hit = (a == r);
    endfunction

    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && penable && !pwrite;
    assign pready  = 1'b1;
    assign addr_ok = addr_hit(paddr, ADDR_AXIS_MODE_3) || addr_hit(paddr, ADDR_GEN_OUT_BANK)
                  || addr_hit(paddr, ADDR_INTERP_MODE) || addr_hit(paddr, ADDR_CMD_DATA_LOW)
                  || addr_hit(paddr, ADDR_CMD_DATA_HIGH) || addr_hit(paddr, ADDR_MAIN_STATUS)
                  || addr_hit(paddr, ADDR_AXIS_SELECT);
    assign pslverr = psel && penable && !addr_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            axis_sel_q <= 2'h0;
        end else if (wr_en && addr_hit(paddr, ADDR_AXIS_SELECT)) begin
            axis_sel_q <= pwdata[1:0];
        end
    end

    genvar g;
    generate
        for (g = 0; g < NAXES; g++) begin : g_axis
            logic [1:0] ext_mode;
            logic       plus_fall;
            logic       plus_rise;
            logic       minus_fall;

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    mode3_q[g] <= MODE3_RESET;
                end else if (wr_en && addr_hit(paddr, ADDR_AXIS_MODE_3) && axis_sel_q == 2'(g)) begin
                    mode3_q[g] <= pwdata[15:0] & MODE3_WRITE_MASK;
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    plus_prev_q[g]  <= 1'b1;
                    minus_prev_q[g] <= 1'b1;
                end else begin
                    plus_prev_q[g]  <= ext_plus_drive_input_n[g];
                    minus_prev_q[g] <= ext_minus_drive_input_n[g];
                end
            end

            assign ext_mode   = mode3_q[g][M3_EXT_LO+1:M3_EXT_LO];
            assign plus_fall  = plus_prev_q[g] && !ext_plus_drive_input_n[g];
            assign plus_rise  = !plus_prev_q[g] && ext_plus_drive_input_n[g];
            assign minus_fall = minus_prev_q[g] && !ext_minus_drive_input_n[g];

            always_comb begin
                ext_req[g] = '0;
                case (ext_mode)
                    EXT_CONT: begin
                        ext_req[g].cont_plus  = !ext_plus_drive_input_n[g];
                        ext_req[g].cont_minus = !ext_minus_drive_input_n[g];
                    end
                    EXT_FIXED: begin
                        ext_req[g].fixed_plus  = plus_fall;
                        ext_req[g].fixed_minus = minus_fall;
                    end
                    // mpg edges, minus low; falling taken as minus
                    EXT_MPG: begin
                        ext_req[g].fixed_plus  = plus_rise && !ext_minus_drive_input_n[g];
                        ext_req[g].fixed_minus = plus_fall && !ext_minus_drive_input_n[g];
                    end
                    default: ext_req[g] = '0;
                endcase
            end

            // general purpose levels level polarity compare accel decel
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    upper_axis_outputs[g*4 +: 4] <= 4'h0;
                end else if (mode3_q[g][M3_OUTSEL]) begin
                    upper_axis_outputs[g*4 +: 4] <= {axis_decel[g] && axis_pulsing[g],
                                                     axis_accel[g] && axis_pulsing[g],
                                                     pos_lt_minus_cmp[g], pos_ge_plus_cmp[g]};
                end else begin
                    upper_axis_outputs[g*4 +: 4] <= mode3_q[g][M3_LEVEL_LO+3:M3_LEVEL_LO];
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    drv_hold_q[g] <= 1'b0;
                end else if (axis_pulsing[g] || home_search_busy[g]) begin
                    drv_hold_q[g] <= inpos_check_en[g];
                end else if (in_position_input[g]) begin
                    drv_hold_q[g] <= 1'b0;
                end
            end
            assign axis_driving_flag[g] = axis_pulsing[g] || home_search_busy[g] || drv_hold_q[g];

            assign axis_err_flag[g] = |axis_err_bits[g*6 +: 6] || |axis_finish_err_bits[g*4 +: 4];

            property p_upper_gp;
                @(posedge pclk) disable iff (!presetn)
                !mode3_q[g][M3_OUTSEL] |=> upper_axis_outputs[g*4 +: 4] == $past(mode3_q[g][11:8]);
            endproperty
            a_upper_gp: assert property (p_upper_gp) else $error("gp upper outputs wrong");

            property p_cmp_out;
                @(posedge pclk) disable iff (!presetn)
                mode3_q[g][M3_OUTSEL] |=> upper_axis_outputs[g*4] == $past(pos_ge_plus_cmp[g])
                                        && upper_axis_outputs[g*4+1] == $past(pos_lt_minus_cmp[g]);
            endproperty
            a_cmp_out: assert property (p_cmp_out) else $error("compare outputs wrong");

            property p_status_out;
                @(posedge pclk) disable iff (!presetn)
                mode3_q[g][M3_OUTSEL] |=>
                    upper_axis_outputs[g*4+2] == ($past(axis_accel[g]) && $past(axis_pulsing[g]))
                    && upper_axis_outputs[g*4+3] == ($past(axis_decel[g]) && $past(axis_pulsing[g]));
            endproperty
            a_status_out: assert property (p_status_out) else $error("drive status outputs wrong");

            property p_fixed_fall;
                @(posedge pclk) disable iff (!presetn)
                (ext_mode == EXT_FIXED && $fell(ext_plus_drive_input_n[g])) |-> ext_req[g].fixed_plus;
            endproperty
            a_fixed_fall: assert property (p_fixed_fall) else $error("fixed plus start missed");

            property p_fixed_minus;
                @(posedge pclk) disable iff (!presetn)
                (ext_mode == EXT_FIXED && $fell(ext_minus_drive_input_n[g])) |-> ext_req[g].fixed_minus;
            endproperty
            a_fixed_minus: assert property (p_fixed_minus) else $error("fixed minus start missed");

            property p_cont;
                @(posedge pclk) disable iff (!presetn)
                ext_mode == EXT_CONT |-> ext_req[g].cont_minus == !ext_minus_drive_input_n[g];
            endproperty
            a_cont: assert property (p_cont) else $error("continuous minus wrong");

            property p_off;
                @(posedge pclk) disable iff (!presetn)
                ext_mode == EXT_OFF |-> ext_req[g] == '0;
            endproperty
            a_off: assert property (p_off) else $error("disabled mode requested drive");

            property p_mpg;
                @(posedge pclk) disable iff (!presetn)
                (ext_mode == EXT_MPG && ext_minus_drive_input_n[g]) |-> !ext_req[g].fixed_plus;
            endproperty
            a_mpg: assert property (p_mpg) else $error("mpg drive without minus low");

            property p_mpg_rise;
                @(posedge pclk) disable iff (!presetn)
                (ext_mode == EXT_MPG && !ext_minus_drive_input_n[g] && $rose(ext_plus_drive_input_n[g]))
                    |-> ext_req[g].fixed_plus;
            endproperty
            a_mpg_rise: assert property (p_mpg_rise) else $error("mpg plus start missed");

            property p_reserved;
                @(posedge pclk) disable iff (!presetn)
                (mode3_q[g] & ~MODE3_WRITE_MASK) == 16'h0000;
            endproperty
            a_reserved: assert property (p_reserved) else $error("reserved mode bits set");

            property p_drv;
                @(posedge pclk) disable iff (!presetn)
                (axis_pulsing[g] && inpos_check_en[g]) ##1 (!axis_pulsing[g] && !home_search_busy[g]
                    && !in_position_input[g]) |-> axis_driving_flag[g];
            endproperty
            a_drv: assert property (p_drv) else $error("drive flag dropped before in position");
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gen_out_q <= GEN_OUT_RESET;
        end else if (wr_en && addr_hit(paddr, ADDR_GEN_OUT_BANK)) begin
            gen_out_q <= pwdata[15:0];
        end
    end
    assign lower_axis_outputs = gen_out_q;

    // axis codes code ten kept off step pacing irq enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interp_q <= INTERP_RESET;
        end else if (wr_en && addr_hit(paddr, ADDR_INTERP_MODE)) begin
            interp_q <= pwdata[15:0];
            if (pwdata[9:8] == VEC_BAD) begin
                interp_q[9:8] <= 2'h0;
            end
        end
    end
    assign interp_cfg.master_axis_select = interp_q[1:0];
    assign interp_cfg.second_axis_select = interp_q[3:2];
    assign interp_cfg.third_axis_select  = interp_q[5:4];
    assign interp_cfg.vector_speed_mode  = interp_q[9:8];
    assign interp_cfg.external_step_mode = interp_q[11];
    assign interp_cfg.command_step_mode  = interp_q[12];
    assign interp_cfg.interp_irq_enable  = interp_q[14];
    assign interp_cfg.pattern_irq_enable = interp_q[15];

    // words in either order; left to software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_low_q        <= 16'h0000;
            cmd_high_q       <= 16'h0000;
            cmd_low_written  <= 1'b0;
            cmd_high_written <= 1'b0;
        end else begin
            cmd_low_written  <= wr_en && addr_hit(paddr, ADDR_CMD_DATA_LOW);
            cmd_high_written <= wr_en && addr_hit(paddr, ADDR_CMD_DATA_HIGH);
            if (wr_en && addr_hit(paddr, ADDR_CMD_DATA_LOW)) begin
                cmd_low_q <= pwdata[15:0];
            end
            if (wr_en && addr_hit(paddr, ADDR_CMD_DATA_HIGH)) begin
                cmd_high_q <= pwdata[15:0];
            end
        end
    end
    assign command_data = {cmd_high_q, cmd_low_q};

    // interp flag ready zone stack count
    assign main_status = {1'b0, pattern_stack_count, circle_zone, next_node_ready, interp_pulsing,
                          axis_err_flag[3:0], axis_driving_flag[3:0]};

    // write-only registers read as zero; only status and axis select are observable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            if (addr_hit(paddr, ADDR_MAIN_STATUS)) begin
                prdata <= {16'h0000, main_status};
            end else if (addr_hit(paddr, ADDR_AXIS_SELECT)) begin
                prdata <= {30'h0, axis_sel_q};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    property p_gen_out;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && addr_hit(paddr, ADDR_GEN_OUT_BANK)) |=> lower_axis_outputs == $past(pwdata[15:0]);
    endproperty
    a_gen_out: assert property (p_gen_out) else $error("output bank not updated");

    property p_vec;
        @(posedge pclk) disable iff (!presetn)
        interp_cfg.vector_speed_mode != VEC_BAD;
    endproperty
    a_vec: assert property (p_vec) else $error("forbidden vector speed code");

    property p_cmd;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && addr_hit(paddr, ADDR_CMD_DATA_HIGH)) |=> command_data[31:16] == $past(pwdata[15:0]);
    endproperty
    a_cmd: assert property (p_cmd) else $error("high command word lost");

    property p_idrv;
        @(posedge pclk) disable iff (!presetn)
        (rd_en && addr_hit(paddr, ADDR_MAIN_STATUS)) |-> prdata[8] == $past(interp_pulsing)
            && prdata[14:13] == $past(pattern_stack_count);
    endproperty
    a_idrv: assert property (p_idrv) else $error("status field mismatch");

    property p_zone;
        @(posedge pclk) disable iff (!presetn)
        (rd_en && addr_hit(paddr, ADDR_MAIN_STATUS)) |-> prdata[12:10] == $past(circle_zone)
            && prdata[9] == $past(next_node_ready);
    endproperty
    a_zone: assert property (p_zone) else $error("zone or next node field mismatch");

    property p_err;
        @(posedge pclk) disable iff (!presetn)
        (rd_en && addr_hit(paddr, ADDR_MAIN_STATUS)) |->
            prdata[4] == (|$past(axis_err_bits[5:0]) || |$past(axis_finish_err_bits[3:0]));
    endproperty
    a_err: assert property (p_err) else $error("axis error flag mismatch");

    property p_interp_axes;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && addr_hit(paddr, ADDR_INTERP_MODE)) |=>
            interp_cfg.master_axis_select == $past(pwdata[1:0])
            && interp_cfg.second_axis_select == $past(pwdata[3:2])
            && interp_cfg.third_axis_select == $past(pwdata[5:4]);
    endproperty
    a_interp_axes: assert property (p_interp_axes) else $error("axis assignment not stored");

    property p_step_mode;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && addr_hit(paddr, ADDR_INTERP_MODE)) |=> interp_cfg.external_step_mode == $past(pwdata[11])
            && interp_cfg.command_step_mode == $past(pwdata[12]);
    endproperty
    a_step_mode: assert property (p_step_mode) else $error("step mode bits not stored");
endmodule

/* tb/mar_host.sv */
`timescale 1ns/1ps
// host side: apb master, request held until pready is seen high or 64 access cycles pass
module mar_host (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    int timeouts = 0;

    initial begin
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
    end

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        // bounded wait so a stuck slave cannot hang the run
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 64);
        if (n >= 64)
            timeouts++;
        q = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
    $display("mismatch %s exp %h got %h", nm, (e), (g)); end end
module tb;
    import mar_pkg::*;
    logic                 pclk = 1'h0;
    logic                 presetn, psel, penable, pwrite, pready, pslverr, ipul, nnr, cl, ch, e;
    logic [11:0]          paddr;
    logic [31:0]          pwdata, prdata, cmd, q, v;
    logic [3:0]           ep_n, em_n, ge, lt, acc, dec, pul, home, ipen, inpos;
    logic [23:0]          errb;
    logic [15:0]          ferr, upper, lower, d, l, h;
    logic [2:0]           zone;
    logic [1:0]           bpsc;
    mar_ext_req_t [3:0]   ext_req;
    mar_interp_cfg_t      cfg;
    int                   failures = 0, samples_checked = 0, seed = 32'h35c93535, m3[4];

    always #12.5 pclk = ~pclk;

    mar_host u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
                     .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    mar_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_plus_drive_input_n(ep_n), .ext_minus_drive_input_n(em_n), .pos_ge_plus_cmp(ge),
        .pos_lt_minus_cmp(lt), .axis_accel(acc), .axis_decel(dec), .axis_pulsing(pul),
        .home_search_busy(home), .inpos_check_en(ipen), .in_position_input(inpos), .axis_err_bits(errb),
        .axis_finish_err_bits(ferr), .interp_pulsing(ipul), .next_node_ready(nnr), .circle_zone(zone),
        .pattern_stack_count(bpsc), .ext_req(ext_req), .upper_axis_outputs(upper),
        .lower_axis_outputs(lower), .interp_cfg(cfg), .command_data(cmd), .cmd_low_written(cl),
        .cmd_high_written(ch));

    task print_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task xf(input logic w, input logic [11:0] a, input logic [31:0] wd);
        u_host.xfer(w, a, wd, q, e);
        if (u_host.timeouts != 0) begin
            failures++;
            print_verdict();
        end
    endtask

    task step(int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    // model of the four upper outputs from the mode three copy
    function automatic logic [3:0] up_exp(int a);
        if (m3[a][7])
            return {dec[a] & pul[a], acc[a] & pul[a], lt[a], ge[a]};
        return 4'(m3[a] >> 8);
    endfunction

    function automatic logic [15:0] st_exp();
        logic [15:0] s;
        s = {1'h0, bpsc, zone, nnr, ipul, 8'h0};
        for (int a = 0; a < 4; a++) begin
            s[a] = pul[a] | home[a];
            s[4+a] = (|errb[a*6+:6]) | (|ferr[a*4+:4]);
        end
        return s;
    endfunction

    // drive one pair of ext inputs, then count fixed pulses over eight cycles
    task ext_seq(int a, logic p, logic m, logic [1:0] ce, logic [3:0] fpe, logic [3:0] fme);
        logic [3:0] fp, fm;
        fp = 4'h0;
        fm = 4'h0;
        @(posedge pclk);
        ep_n[a] <= p;
        em_n[a] <= m;
        repeat (8) begin
            #1;
            fp += ext_req[a].fixed_plus;
            fm += ext_req[a].fixed_minus;
            @(posedge pclk);
        end
        #1;
        `CHK("ext_cont", ce, {ext_req[a].cont_plus, ext_req[a].cont_minus})
        `CHK("ext_fixed_plus", fpe, fp)
        `CHK("ext_fixed_minus", fme, fm)
    endtask

    initial begin
        presetn = 1'h0;
        {ep_n, em_n} = 8'hff;
        {ge, lt, acc, dec, pul, home, ipen, inpos, errb, ferr, ipul, nnr, zone, bpsc} = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        step(1);
        `CHK("reset_outs", 48'h0, {upper, lower, cfg})
        for (int i = 0; i < 5; i++) begin
            xf(1'h0, 12'(i * 4), 32'h0);
            `CHK("reset_read", 32'h0, q)
        end
        $display("test reset done");
        for (int a = 0; a < 4; a++) begin
            xf(1'h1, ADDR_AXIS_SELECT, 32'(a));
            // reserved mode three bits are written as zero
            d = {4'h0, 4'($random(seed)), 3'h0, 2'(a), 3'($random(seed))};
            xf(1'h1, ADDR_AXIS_MODE_3, {16'h0, d});
            m3[a] = 32'(d & MODE3_WRITE_MASK);
        end
        xf(1'h0, ADDR_AXIS_SELECT, 32'h0);
        `CHK("axis_select", 2'h3, q[1:0])
        step(2);
        for (int a = 0; a < 4; a++)
            `CHK("upper_gp", up_exp(a), upper[a*4+:4])
        for (int a = 0; a < 4; a++) begin
            ext_seq(a, 1'h0, 1'h1, a == 1 ? 2'h2 : 2'h0, 4'(a == 2), 4'h0);
            ext_seq(a, 1'h1, 1'h1, 2'h0, 4'h0, 4'h0);
            ext_seq(a, 1'h1, 1'h0, a == 1 ? 2'h1 : 2'h0, 4'h0, 4'(a == 2));
            ext_seq(a, 1'h0, 1'h0, a == 1 ? 2'h3 : 2'h0, 4'(a == 2), 4'(a == 3));
            ext_seq(a, 1'h1, 1'h0, a == 1 ? 2'h1 : 2'h0, 4'(a == 3), 4'h0);
            ext_seq(a, 1'h1, 1'h1, 2'h0, 4'h0, 4'h0);
        end
        $display("test ext_drive done");
        for (int a = 0; a < 4; a++) begin
            xf(1'h1, ADDR_AXIS_SELECT, 32'(a));
            m3[a] = m3[a] | 32'h80;
            xf(1'h1, ADDR_AXIS_MODE_3, 32'(m3[a]));
        end
        repeat (4) begin
            @(posedge pclk);
            {ge, lt, acc, dec, pul} <= 20'($random(seed));
            step(3);
            for (int a = 0; a < 4; a++)
                `CHK("upper_status", up_exp(a), upper[a*4+:4])
        end
        $display("test upper_outputs done");
        repeat (3) begin
            v = $random(seed);
            xf(1'h1, ADDR_GEN_OUT_BANK, v);
            step(2);
            `CHK("lower_outputs", v[15:0], lower)
        end
        for (int i = 0; i < 6; i++) begin
            v = $random(seed);
            v[9:8] = 2'(i);
            xf(1'h1, ADDR_INTERP_MODE, v);
            step(2);
            if (v[9:8] == VEC_BAD)
                v[9:8] = 2'h0;
            `CHK("interp_cfg", {v[1:0], v[3:2], v[5:4], v[9:8], v[11], v[12], v[14], v[15]}, cfg)
        end
        $display("test interp done");
        for (int i = 0; i < 2; i++) begin
            l = $random(seed);
            h = $random(seed);
            xf(1'h1, i ? ADDR_CMD_DATA_HIGH : ADDR_CMD_DATA_LOW, {16'h0, i ? h : l});
            #1;
            `CHK("cmd_first_pulse", {1'(i), 1'(!i)}, {ch, cl})
            xf(1'h1, i ? ADDR_CMD_DATA_LOW : ADDR_CMD_DATA_HIGH, {16'h0, i ? l : h});
            #1;
            `CHK("cmd_second_pulse", {1'(!i), 1'(i)}, {ch, cl})
            step(1);
            `CHK("cmd_data", {h, l}, cmd)
            `CHK("cmd_pulse_end", 2'h0, {ch, cl})
        end
        $display("test cmd_data done");
        repeat (4) begin
            @(posedge pclk);
            {pul, home, errb, ferr, ipul, nnr, zone, bpsc} <= 55'({$random(seed), $random(seed)});
            xf(1'h1, ADDR_MAIN_STATUS, 32'hffff);
            step(2);
            xf(1'h0, ADDR_MAIN_STATUS, 32'h0);
            `CHK("main_status", {16'h0, st_exp()}, q)
        end
        @(posedge pclk);
        {ipen, pul, home, inpos} <= 16'hf100;
        step(3);
        @(posedge pclk);
        pul <= 4'h0;
        step(3);
        xf(1'h0, ADDR_MAIN_STATUS, 32'h0);
        `CHK("drive_hold", 1'h1, q[0])
        @(posedge pclk);
        inpos <= 4'hf;
        step(3);
        xf(1'h0, ADDR_MAIN_STATUS, 32'h0);
        `CHK("drive_release", 1'h0, q[0])
        $display("test main_status done");
        xf(1'h0, 12'h01c, 32'h0);
        `CHK("unmapped", 33'h100000000, {e, q})
        $display("test unmapped done");
        print_verdict();
    end
endmodule
